// File: shared/tad_regs.svh
// Purpose: Opcode patterns, masks and state counts of the transfer decoder.
// Assumes: All counts are core states; one state is one sys_clk_in cycle.
// Notes: Definitions only.
`ifndef TAD_REGS_SVH
`define TAD_REGS_SVH
// ==========================================================================
// First-byte opcodes and masks
`define TAD_OP_MOV_R_A 8'h18
`define TAD_OP_MOV_A_R 8'h08
`define TAD_MSK_F8 8'hf8
`define TAD_OP_SR_A 8'h4d
`define TAD_OP_A_SR 8'h4c
`define TAD_OP_P70 8'h70
`define TAD_OP_P48 8'h48
`define TAD_OP_MVI 8'h68
`define TAD_OP_MVI_SR 8'h64
`define TAD_OP_MVW 8'h71
`define TAD_OP_STORE_ACC_WORKING 8'h63
`define TAD_OP_LOAD_ACC_WORKING 8'h01
`define TAD_OP_STORE_ACC_INDIRECT 8'h38
`define TAD_OP_LOAD_ACC_INDIRECT 8'h28
`define TAD_MSK_IND 8'h78
`define TAD_OP_EXX 8'h11
`define TAD_OP_EXA 8'h10
`define TAD_OP_EXH 8'h50
`define TAD_OP_BLOCK 8'h31
`define TAD_OP_WIDE_MOVE_TO 8'hb4
`define TAD_OP_WIDE_MOVE_FR 8'ha4
`define TAD_MSK_FC 8'hfc
`define TAD_OP_PUSH 8'hb0
`define TAD_OP_POP 8'ha0
`define TAD_OP_LXI 8'h04
`define TAD_MSK_LXI 8'h8f
`define TAD_OP_ARITH_R 8'h60
// ==========================================================================
// Second-byte patterns
`define TAD_B2_SR 2'b11
`define TAD_B2_LD_DIR 8'h68
`define TAD_B2_ST_DIR 8'h78
`define TAD_B2_PAIR_ST 8'h0e
`define TAD_MSK_PAIR 8'hce
`define TAD_B2_STORE_WIDE_INDIRECT 4'h9
`define TAD_B2_LOAD_WIDE_INDIRECT 4'h8
`define TAD_B2_TABLE 8'ha8
`define TAD_B2_WIDE_MOVE_SR4 7'h60
`define TAD_B2_WIDE_MOVE_SR3 7'h69
// ==========================================================================
// State counts
`define TAD_ST_1B 12'd4
`define TAD_ST_MOV_SR 12'd10
`define TAD_ST_DIR 12'd17
`define TAD_ST_MVI 12'd7
`define TAD_ST_MVI_SR 12'd14
`define TAD_ST_WORK 12'd10
`define TAD_ST_MVW 12'd13
`define TAD_ST_IND 12'd7
`define TAD_ST_IND_X 12'd13
`define TAD_ST_BLOCK 12'd13
`define TAD_ST_WIDE_MOVE_SR 12'd14
`define TAD_ST_DIR_PAIR 12'd20
`define TAD_ST_WIDE 12'd14
`define TAD_ST_WIDE_X 12'd20
`define TAD_ST_PUSH 12'd13
`define TAD_ST_POP 12'd10
`define TAD_ST_LXI 12'd10
`define TAD_ST_TABLE 12'd17
`define TAD_ST_ARITH_R 12'd8
`define TAD_ST_ARITH_M 12'd11
`define TAD_ST_SKIP1 12'd4
`define TAD_ST_SKIP2 12'd8
`define TAD_ST_SKIP3 12'd11
`define TAD_TABLE_OFS 16'd3
`endif

// File: shared/tad_pkg.sv
// Purpose: Types of the transfer decoder.
// Assumes: Nothing beyond the constants header.
// Notes: Addressing codes equal the enum values.
package tad_pkg;
  typedef enum logic [2:0] {TAD_V, TAD_A, TAD_B, TAD_C, TAD_D, TAD_E, TAD_H, TAD_L} tad_greg_t;
  typedef enum logic [2:0] {
    TAD_P_SP, TAD_P_BC, TAD_P_DE, TAD_P_HL, TAD_P_EA, TAD_P_VA, TAD_P_NONE
  } tad_pair_t;
  typedef enum logic [3:0] {
    TAD_AM_NONE = 4'h0, TAD_AM_BC = 4'h1, TAD_AM_DE = 4'h2, TAD_AM_HL = 4'h3,
    TAD_AM_DE_INC = 4'h4, TAD_AM_HL_INC = 4'h5, TAD_AM_DE_DEC = 4'h6, TAD_AM_HL_DEC = 4'h7,
    TAD_AM_DE_BYTE = 4'hb, TAD_AM_HL_A = 4'hc, TAD_AM_HL_B = 4'hd, TAD_AM_HL_EA = 4'he,
    TAD_AM_HL_BYTE = 4'hf
  } tad_amode_t;
  typedef enum logic [4:0] {
    TAD_K_ILLEGAL, TAD_K_MOV_R, TAD_K_MOV_SR, TAD_K_MOV_DIR, TAD_K_MVI, TAD_K_MVI_SR,
    TAD_K_WORK, TAD_K_MVW, TAD_K_IND, TAD_K_SWAP_PAIR, TAD_K_SWAP_ACC, TAD_K_SWAP_PTR,
    TAD_K_BLOCK, TAD_K_WIDE_MOVE, TAD_K_WIDE_MOVE_SR, TAD_K_DIR_PAIR, TAD_K_WIDE, TAD_K_PUSH,
    TAD_K_POP, TAD_K_LXI, TAD_K_TABLE, TAD_K_ARITH_R, TAD_K_ARITH_M
  } tad_kind_t;
  typedef enum logic [1:0] {TAD_S_FIRST = 2'b01, TAD_S_REST = 2'b10} tad_state_t;
  typedef struct packed {
    tad_kind_t kind;
    logic [2:0] len;
    logic [11:0] states;
    logic skipped;
    logic store;
    tad_greg_t greg;
    logic [5:0] sreg;
    logic sel;
    tad_pair_t pair;
    tad_amode_t amode;
    logic [15:0] addr;
    logic [7:0] data;
    logic [7:0] disp;
    logic disp_ok;
    logic signed [2:0] ptr_adj;
    logic signed [2:0] sp_adj;
  } tad_dec_t;
endpackage : tad_pkg

// File: shared/tad_fld_if.sv
// Purpose: Carries operand field codes to the field decoder and results back.
// Assumes: Purely combinational between the two ends.
// Notes: One modport per end.
`timescale 1ns/1ps
`default_nettype none
interface tad_fld_if;
  import tad_pkg::*;
  logic [2:0] greg_code;
  logic [5:0] sreg_code;
  logic [2:0] rp_code;
  logic [2:0] rp1_code;
  logic [3:0] rpa_code;
  logic [3:0] wide_indirect_mode_code;
  logic [4:0] irf_code;
  tad_greg_t greg;
  logic sreg_ok;
  logic sreg_conv;
  tad_pair_t rp;
  tad_pair_t rp1;
  logic rpa_ok;
  logic wide_indirect_mode_ok;
  logic [17:0] irf_hot;
  modport dec (output greg_code, sreg_code, rp_code, rp1_code, rpa_code, wide_indirect_mode_code, irf_code,
               input greg, sreg_ok, sreg_conv, rp, rp1, rpa_ok, wide_indirect_mode_ok, irf_hot);
  modport fld (input greg_code, sreg_code, rp_code, rp1_code, rpa_code, wide_indirect_mode_code, irf_code,
               output greg, sreg_ok, sreg_conv, rp, rp1, rpa_ok, wide_indirect_mode_ok, irf_hot);
endinterface : tad_fld_if
`default_nettype wire

// File: verilog/tad_field_dec.sv
// Purpose: Decodes operand fields: registers, pairs, addressing, interrupt flags.
// Assumes: Codes are stable within the cycle.
// Notes: Purely combinational.
`timescale 1ns/1ps
`default_nettype none
module tad_field_dec (
  tad_fld_if.fld f
);
  import tad_pkg::*;
  always_comb begin
    f.greg = tad_greg_t'(f.greg_code);
    f.sreg_ok = f.sreg_code inside {[6'h00:6'h04], [6'h06:6'h0d], [6'h10:6'h14],
                                    [6'h17:6'h1b], [6'h20:6'h23], 6'h28};
    f.sreg_conv = (f.sreg_code[5:2] == 4'h8);
    case (f.rp_code)
      3'h0: f.rp = TAD_P_SP;
      3'h1: f.rp = TAD_P_BC;
      3'h2: f.rp = TAD_P_DE;
      3'h3: f.rp = TAD_P_HL;
      3'h4: f.rp = TAD_P_EA;
      default: f.rp = TAD_P_NONE;
    endcase
    case (f.rp1_code)
      3'h0: f.rp1 = TAD_P_VA;
      3'h1: f.rp1 = TAD_P_BC;
      3'h2: f.rp1 = TAD_P_DE;
      3'h3: f.rp1 = TAD_P_HL;
      3'h4: f.rp1 = TAD_P_EA;
      default: f.rp1 = TAD_P_NONE;
    endcase
    f.rpa_ok = (f.rpa_code != 4'h0) && !(f.rpa_code inside {[4'h8:4'ha]});
    f.wide_indirect_mode_ok = f.wide_indirect_mode_code inside {[4'h2:4'h5], [4'hb:4'hf]};
  end
  // Codes 13 to 15 select no flag; the analog and standby flags start at code 16.
  for (genvar i = 0; i < 18; i++) begin : g_irf
    localparam logic [4:0] CODE = (i < 13) ? 5'(i) : 5'(i + 3);
    assign f.irf_hot[i] = (f.irf_code == CODE);
  end
endmodule : tad_field_dec
`default_nettype wire

// File: verilog/tad_decoder.sv
// Purpose: Collects instruction bytes and decodes transfer and 8-bit arithmetic opcodes.
// Assumes: Bytes come from the core fetch logic on sys_clk_in, one per valid cycle.
// Notes: One decode record per instruction, held until the next one completes.
// Function
// - Register field codes 0-7 select V..L.
// - Special register field decodes ports, masks, converter.
// - Wide special moves: select bit picks register.
// - Load pair field: SP, BC, DE, HL, EA.
// - Push/pop pair field: VA, BC, DE, HL, EA.
// - Byte indirect field decodes pointer modes.
// - Wide indirect field decodes pointer modes.
// - Interrupt flag selector maps codes to flags.
// - Special register moves: 2 bytes, 10 states.
// - Direct register load/store: 4 bytes, 17 states.
// - Immediate loads: 2/7 general, 3/14 special.
// - Working address is V joined with offset.
// - Indirect accumulator access: 7 or 13 states.
// - Byte indirect displacement modes take second byte as displacement; wide indirect ones take the third.
// - Bank swaps: one byte, 4 states.
// - Block copy costs 13 states per byte.
// - Pair-accumulator wide moves take 4 states.
// - Direct pair store/load: 4 bytes, 20 states.
// - Wide indirect: 3 bytes, 14 or 20.
// - Push 13 states, pop 10, step two.
// - Table reads at PC plus 3 plus A.
// - Register arithmetic: 2 bytes, 8 states.
// - Indirect memory arithmetic: 2 bytes, 11 states.
// - Skipped instructions cost 4, 8, 11 states.
`include "tad_regs.svh"
`timescale 1ns/1ps
`default_nettype none
module tad_decoder (
  // Clock and reset
  input wire logic sys_clk_in,
  input wire logic reset_in,
  // Instruction byte stream
  input wire logic byte_valid_in,
  input wire logic [7:0] byte_in,
  input wire logic skip_in,
  // Core register values used for addresses and counts
  input wire logic [7:0] v_in,
  input wire logic [7:0] a_in,
  input wire logic [7:0] c_in,
  input wire logic [15:0] pc_in,
  input wire logic [4:0] irf_code_in,
  // Decode result
  output logic dec_valid_out,
  output tad_pkg::tad_dec_t dec_out,
  output logic [17:0] irf_sel_out,
  output logic sreg_conv_out
);
  import tad_pkg::*;
  tad_fld_if fld ();
  tad_field_dec u_fld (
    .f(fld)
  );

  // ==========================================================================
  // Byte collection
  tad_state_t state;
  tad_state_t next_state;
  logic [1:0] cnt;
  logic [1:0] next_cnt;
  logic [7:0] held [0:3];
  logic [7:0] next_held [0:3];
  logic [7:0] nb [0:3];
  tad_dec_t d;
  tad_dec_t next_dec;
  logic next_valid;
  logic [17:0] next_irf;
  logic next_conv;

  // The byte arriving now joins the held ones so decode finishes without a spare cycle.
  for (genvar i = 0; i < 4; i++) begin : g_nb
    assign nb[i] = (cnt == 2'(i)) ? byte_in : held[i];
  end

  // ==========================================================================
  // Field codes steered by opcode
  always_comb begin
    fld.greg_code = ((nb[0] == `TAD_OP_ARITH_R) || (nb[0] == `TAD_OP_P70)) ? nb[1][2:0] : nb[0][2:0];
    fld.sreg_code = (nb[0] == `TAD_OP_MVI_SR) ? {2'b00, nb[1][7], nb[1][2:0]} : nb[1][5:0];
    if ((nb[0] & `TAD_MSK_LXI) == `TAD_OP_LXI) begin
      fld.rp_code = nb[0][6:4];
    end else if (nb[0] == `TAD_OP_P70) begin
      fld.rp_code = {1'b0, nb[1][5:4]};
    end else begin
      fld.rp_code = {1'b0, nb[0][1:0]};
    end
    fld.rp1_code = nb[0][2:0];
    fld.rpa_code = (nb[0] == `TAD_OP_P70) ? {1'b0, nb[1][2:0]} : {nb[0][7], nb[0][2:0]};
    fld.wide_indirect_mode_code = nb[1][3:0];
    fld.irf_code = irf_code_in;
  end

  // ==========================================================================
  // Instruction decode
  always_comb begin
    d = '0;
    d.kind = TAD_K_ILLEGAL;
    d.len = 3'd1;
    d.states = `TAD_ST_1B;
    d.greg = fld.greg;
    d.sreg = fld.sreg_code;
    d.pair = TAD_P_NONE;
    d.amode = TAD_AM_NONE;
    if (((nb[0] & `TAD_MSK_F8) == `TAD_OP_MOV_R_A) || ((nb[0] & `TAD_MSK_F8) == `TAD_OP_MOV_A_R)) begin
      d.kind = TAD_K_MOV_R;
      d.store = nb[0][4];
      d.states = `TAD_ST_1B;
    end else if ((nb[0] == `TAD_OP_SR_A) || (nb[0] == `TAD_OP_A_SR)) begin
      d.len = 3'd2;
      d.kind = (nb[1][7:6] == `TAD_B2_SR) ? TAD_K_MOV_SR : TAD_K_ILLEGAL;
      d.store = nb[0][0];
      d.states = `TAD_ST_MOV_SR;
    end else if (nb[0] == `TAD_OP_P70) begin
      d.len = 3'd2;
      if (nb[1][7]) begin
        d.kind = TAD_K_ARITH_M;
        d.amode = tad_amode_t'(fld.rpa_code);
        d.states = `TAD_ST_ARITH_M;
      end else if (((nb[1] & `TAD_MSK_F8) == `TAD_B2_LD_DIR) || ((nb[1] & `TAD_MSK_F8) == `TAD_B2_ST_DIR)) begin
        d.kind = TAD_K_MOV_DIR;
        d.len = 3'd4;
        d.store = nb[1][4];
        d.addr = {nb[3], nb[2]};
        d.states = `TAD_ST_DIR;
      end else if ((nb[1] & `TAD_MSK_PAIR) == `TAD_B2_PAIR_ST) begin
        d.kind = TAD_K_DIR_PAIR;
        d.len = 3'd4;
        d.store = !nb[1][0];
        d.pair = fld.rp;
        d.addr = {nb[3], nb[2]};
        d.states = `TAD_ST_DIR_PAIR;
      end
    end else if ((nb[0] & `TAD_MSK_F8) == `TAD_OP_MVI) begin
      d.kind = TAD_K_MVI;
      d.len = 3'd2;
      d.data = nb[1];
      d.states = `TAD_ST_MVI;
    end else if (nb[0] == `TAD_OP_MVI_SR) begin
      d.kind = TAD_K_MVI_SR;
      d.len = 3'd3;
      d.data = nb[2];
      d.states = `TAD_ST_MVI_SR;
    end else if ((nb[0] == `TAD_OP_STORE_ACC_WORKING) || (nb[0] == `TAD_OP_LOAD_ACC_WORKING) || (nb[0] == `TAD_OP_MVW)) begin
      d.kind = (nb[0] == `TAD_OP_MVW) ? TAD_K_MVW : TAD_K_WORK;
      d.store = (nb[0] != `TAD_OP_LOAD_ACC_WORKING);
      d.len = (nb[0] == `TAD_OP_MVW) ? 3'd3 : 3'd2;
      d.addr = {v_in, nb[1]};
      d.data = (nb[0] == `TAD_OP_MVW) ? nb[2] : 8'h00;
      d.states = (nb[0] == `TAD_OP_MVW) ? `TAD_ST_MVW : `TAD_ST_WORK;
    end else if (((nb[0] & `TAD_MSK_IND) == `TAD_OP_STORE_ACC_INDIRECT) || ((nb[0] & `TAD_MSK_IND) == `TAD_OP_LOAD_ACC_INDIRECT)) begin
      d.kind = fld.rpa_ok ? TAD_K_IND : TAD_K_ILLEGAL;
      d.store = nb[0][4];
      d.amode = tad_amode_t'(fld.rpa_code);
      d.disp_ok = (fld.rpa_code == TAD_AM_DE_BYTE) || (fld.rpa_code == TAD_AM_HL_BYTE);
      d.len = d.disp_ok ? 3'd2 : 3'd1;
      d.disp = d.disp_ok ? nb[1] : 8'h00;
      d.states = fld.rpa_code[3] ? `TAD_ST_IND_X : `TAD_ST_IND;
      if (fld.rpa_code inside {TAD_AM_DE_INC, TAD_AM_HL_INC}) begin
        d.ptr_adj = 3'sd1;
      end else if (fld.rpa_code inside {TAD_AM_DE_DEC, TAD_AM_HL_DEC}) begin
        d.ptr_adj = -3'sd1;
      end
    end else if (nb[0] == `TAD_OP_EXX) begin
      d.kind = TAD_K_SWAP_PAIR;
    end else if (nb[0] == `TAD_OP_EXA) begin
      d.kind = TAD_K_SWAP_ACC;
    end else if (nb[0] == `TAD_OP_EXH) begin
      d.kind = TAD_K_SWAP_PTR;
    end else if (nb[0] == `TAD_OP_BLOCK) begin
      d.kind = TAD_K_BLOCK;
      d.ptr_adj = 3'sd1;
      d.states = ({4'h0, c_in} + 12'd1) * `TAD_ST_BLOCK;
    end else if ((((nb[0] & `TAD_MSK_FC) == `TAD_OP_WIDE_MOVE_TO) || ((nb[0] & `TAD_MSK_FC) == `TAD_OP_WIDE_MOVE_FR))
                 && (nb[0][1:0] != 2'b00)) begin
      d.kind = TAD_K_WIDE_MOVE;
      d.store = nb[0][4];
      d.pair = fld.rp;
      d.states = `TAD_ST_1B;
    end else if (((nb[0] & `TAD_MSK_F8) == `TAD_OP_PUSH) || ((nb[0] & `TAD_MSK_F8) == `TAD_OP_POP)) begin
      d.kind = (fld.rp1 == TAD_P_NONE) ? TAD_K_ILLEGAL : (nb[0][4] ? TAD_K_PUSH : TAD_K_POP);
      d.pair = fld.rp1;
      d.sp_adj = nb[0][4] ? -3'sd2 : 3'sd2;
      d.states = nb[0][4] ? `TAD_ST_PUSH : `TAD_ST_POP;
    end else if (((nb[0] & `TAD_MSK_LXI) == `TAD_OP_LXI) && (fld.rp != TAD_P_NONE)) begin
      d.kind = TAD_K_LXI;
      d.len = 3'd3;
      d.pair = fld.rp;
      d.addr = {nb[2], nb[1]};
      d.states = `TAD_ST_LXI;
    end else if (nb[0] == `TAD_OP_ARITH_R) begin
      d.kind = TAD_K_ARITH_R;
      d.len = 3'd2;
      d.states = `TAD_ST_ARITH_R;
    end else if (nb[0] == `TAD_OP_P48) begin
      d.len = 3'd2;
      if ((nb[1][7:4] == `TAD_B2_STORE_WIDE_INDIRECT) || (nb[1][7:4] == `TAD_B2_LOAD_WIDE_INDIRECT)) begin
        d.kind = fld.wide_indirect_mode_ok ? TAD_K_WIDE : TAD_K_ILLEGAL;
        d.len = 3'd3;
        d.store = nb[1][4];
        d.amode = tad_amode_t'(fld.wide_indirect_mode_code);
        d.disp_ok = (fld.wide_indirect_mode_code == TAD_AM_DE_BYTE) || (fld.wide_indirect_mode_code == TAD_AM_HL_BYTE);
        d.disp = d.disp_ok ? nb[2] : 8'h00;
        d.ptr_adj = (fld.wide_indirect_mode_code inside {TAD_AM_DE_INC, TAD_AM_HL_INC}) ? 3'sd2 : 3'sd0;
        d.states = fld.wide_indirect_mode_code[3] ? `TAD_ST_WIDE_X : `TAD_ST_WIDE;
      end else if (nb[1] == `TAD_B2_TABLE) begin
        d.kind = TAD_K_TABLE;
        d.addr = pc_in + `TAD_TABLE_OFS + {8'h00, a_in};
        d.states = `TAD_ST_TABLE;
      end else if ((nb[1][7:1] == `TAD_B2_WIDE_MOVE_SR4) || (nb[1][7:1] == `TAD_B2_WIDE_MOVE_SR3)) begin
        d.kind = TAD_K_WIDE_MOVE_SR;
        d.store = (nb[1][7:1] == `TAD_B2_WIDE_MOVE_SR3);
        d.sel = nb[1][0];
        d.states = `TAD_ST_WIDE_MOVE_SR;
      end
    end
    if (d.kind == TAD_K_MOV_SR || d.kind == TAD_K_MVI_SR) begin
      d.kind = fld.sreg_ok ? d.kind : TAD_K_ILLEGAL;
    end
    d.skipped = skip_in;
    if (skip_in) begin
      case (d.len)
        3'd1: d.states = `TAD_ST_SKIP1;
        3'd2: d.states = `TAD_ST_SKIP2;
        default: d.states = `TAD_ST_SKIP3;
      endcase
    end
  end

  // ==========================================================================
  // Sequencer
  always_comb begin
    next_state = state;
    next_cnt = cnt;
    next_dec = dec_out;
    next_valid = 1'b0;
    next_irf = fld.irf_hot;
    next_conv = sreg_conv_out;
    for (int k = 0; k < 4; k++) begin
      next_held[k] = held[k];
    end
    if (byte_valid_in) begin
      case (state)
        TAD_S_FIRST, TAD_S_REST: begin
          if ({1'b0, cnt} + 3'd1 >= d.len) begin
            next_state = TAD_S_FIRST;
            next_cnt = 2'd0;
            next_dec = d;
            next_valid = 1'b1;
            next_conv = fld.sreg_conv;
          end else begin
            next_state = TAD_S_REST;
            next_held[cnt] = byte_in;
            next_cnt = cnt + 2'd1;
          end
        end
        default: begin
          next_state = TAD_S_FIRST;
          next_cnt = 2'd0;
        end
      endcase
    end
  end

  always_ff @(posedge sys_clk_in) begin
    if (reset_in) begin
      state <= TAD_S_FIRST;
      cnt <= 2'd0;
      dec_out <= '0;
      dec_valid_out <= 1'b0;
      irf_sel_out <= '0;
      sreg_conv_out <= 1'b0;
      for (int k = 0; k < 4; k++) begin
        held[k] <= 8'h00;
      end
    end else begin
      state <= next_state;
      cnt <= next_cnt;
      dec_out <= next_dec;
      dec_valid_out <= next_valid;
      irf_sel_out <= next_irf;
      sreg_conv_out <= next_conv;
      for (int k = 0; k < 4; k++) begin
        held[k] <= next_held[k];
      end
    end
  end

  // ==========================================================================
  // Checks
  default clocking cb @(posedge sys_clk_in); endclocking
  default disable iff (reset_in);

  sequence s_first(logic [7:0] op);
    byte_valid_in && !skip_in && (state == TAD_S_FIRST) && (byte_in == op);
  endsequence
  sequence s_done(tad_kind_t k, logic [11:0] st);
    dec_valid_out && (dec_out.kind == k) && (dec_out.len == 3'd1) && (dec_out.states == st);
  endsequence

  property p_swap;
    s_first(`TAD_OP_EXX) |=> s_done(TAD_K_SWAP_PAIR, `TAD_ST_1B);
  endproperty
  a_swap: assert property (p_swap) else $error("pair swap decode wrong");
  property p_movr;
    dec_valid_out && dec_out.kind == TAD_K_MOV_R && !dec_out.skipped |-> dec_out.states == 12'd4;
  endproperty
  a_movr: assert property (p_movr) else $error("register move states wrong");
  property p_movsr;
    dec_valid_out && dec_out.kind == TAD_K_MOV_SR && !dec_out.skipped
      |-> dec_out.len == 3'd2 && dec_out.states == 12'd10;
  endproperty
  a_movsr: assert property (p_movsr) else $error("special move timing wrong");
  property p_dir;
    s_first(`TAD_OP_P70) ##1 (byte_valid_in && (byte_in & `TAD_MSK_F8) == `TAD_B2_LD_DIR) ##1 byte_valid_in[*2]
      |=> dec_valid_out && dec_out.kind == TAD_K_MOV_DIR && dec_out.states == 12'd17;
  endproperty
  a_dir: assert property (p_dir) else $error("direct load not done after four bytes");
  property p_ind;
    dec_valid_out && dec_out.kind == TAD_K_IND && !dec_out.skipped
      |-> dec_out.states == (dec_out.amode[3] ? 12'd13 : 12'd7);
  endproperty
  a_ind: assert property (p_ind) else $error("indirect states wrong");
  property p_block;
    s_first(`TAD_OP_BLOCK) |=> dec_out.states == 12'd13 * ({4'h0, $past(c_in)} + 12'd1);
  endproperty
  a_block: assert property (p_block) else $error("block copy states wrong");
  property p_push;
    dec_valid_out && dec_out.kind == TAD_K_PUSH && !dec_out.skipped
      |-> dec_out.sp_adj == -3'sd2 && dec_out.states == 12'd13;
  endproperty
  a_push: assert property (p_push) else $error("push decode wrong");
  property p_skip;
    dec_valid_out && dec_out.skipped
      |-> dec_out.states == ((dec_out.len == 3'd1) ? 12'd4 : (dec_out.len == 3'd2) ? 12'd8 : 12'd11);
  endproperty
  a_skip: assert property (p_skip) else $error("skip idle states wrong");
  property p_table;
    s_first(`TAD_OP_P48) ##1 (byte_valid_in && byte_in == `TAD_B2_TABLE)
      |=> dec_out.addr == $past(pc_in) + 16'd3 + {8'h00, $past(a_in)};
  endproperty
  a_table: assert property (p_table) else $error("table address wrong");
endmodule : tad_decoder
`default_nettype wire

// File: bench/test_tad_decoder.sv
// Purpose: Self-checking bench for the transfer and arithmetic opcode decoder.
// Assumes: One state per clock; the bench feeds whole instructions, then waits for the record.
// Notes: Expected records are rebuilt here from the instruction bytes and the random core values.
`timescale 1ns/1ps
`default_nettype none
module test_tad_decoder;
  import tad_pkg::*;
  logic sys_clk_in, reset_in, byte_valid_in, skip_in, dec_valid_out, sreg_conv_out;
  logic [7:0] byte_in, v_in, a_in, c_in, vv;
  logic [15:0] pc_in, ta;
  logic [4:0] irf_code_in;
  logic [17:0] irf_sel_out;
  tad_dec_t dec_out;
  int n_errors, tests_run, k;
  logic [31:0] seed;
  logic [7:0] q[$];
  tad_decoder u_tad_decoder (.sys_clk_in(sys_clk_in), .reset_in(reset_in), .byte_valid_in(byte_valid_in),
    .byte_in(byte_in), .skip_in(skip_in), .v_in(v_in), .a_in(a_in), .c_in(c_in), .pc_in(pc_in),
    .irf_code_in(irf_code_in), .dec_valid_out(dec_valid_out), .dec_out(dec_out),
    .irf_sel_out(irf_sel_out), .sreg_conv_out(sreg_conv_out));
  // ==========================================================================
  // Helpers
  function automatic logic [31:0] xs(input logic [31:0] s);
    s = s ^ (s << 13);
    s = s ^ (s >> 17);
    return s ^ (s << 5);
  endfunction : xs
  task automatic chk(input string nm, input logic [17:0] exp, input logic [17:0] got);
    tests_run++;
    if (got !== exp) begin
      n_errors++;
      $display("mismatch %s expected %h seen %h", nm, exp, got);
    end
  endtask : chk
  // Core values come from the current seed so callers can predict addresses and counts.
  task automatic ins(input logic sk, input tad_kind_t kd, input logic [2:0] ln, input logic [17:0] st);
    int i;
    foreach (q[j]) begin
      @(posedge sys_clk_in);
      byte_valid_in <= 1'b1;
      byte_in <= q[j];
      skip_in <= sk && (j == q.size() - 1);
      if (j == 0) {pc_in, v_in, a_in, c_in} <= {seed[31:16], seed[23:0]};
    end
    @(posedge sys_clk_in);
    byte_valid_in <= 1'b0;
    skip_in <= 1'b0;
    #1;
    for (i = 0; i < 4 && dec_valid_out !== 1'b1; i++) begin
      @(posedge sys_clk_in);
      #1;
    end
    chk("valid", 18'h1, {17'h0, dec_valid_out});
    chk("kind", {13'h0, kd}, {13'h0, dec_out.kind});
    if (ln != 3'd0) chk("len", {15'h0, ln}, {15'h0, dec_out.len});
    chk("states", st, {6'h0, dec_out.states});
    chk("skipped", {17'h0, sk}, {17'h0, dec_out.skipped});
    seed = xs(seed);
  endtask : ins
  task automatic complete_run;
    $display("errors %0d comparisons %0d", n_errors, tests_run);
    if (n_errors == 0 && tests_run > 0) $display("SIMULATION PASSED");
    else $display("SIMULATION FAILED");
    $finish;
  endtask : complete_run
  // ==========================================================================
  // Clock and watchdog
  initial begin
    sys_clk_in = 1'b0;
    forever #5 sys_clk_in = ~sys_clk_in;
  end
  initial begin
    #100000;
    n_errors++;
    complete_run();
  end
  // ==========================================================================
  // Scenarios
  initial begin
    {reset_in, byte_valid_in, skip_in, byte_in, v_in, a_in, c_in, pc_in, irf_code_in} = '0;
    reset_in = 1'b1;
    n_errors = 0;
    tests_run = 0;
    seed = 32'h7955;
    repeat (10) @(posedge sys_clk_in);
    reset_in <= 1'b0;
    #1;
    chk("reset valid", 18'h0, {17'h0, dec_valid_out});
    chk("reset states", 18'h0, {6'h0, dec_out.states});
    for (k = 0; k < 8; k++) begin
      q = {(k[0] ? 8'h18 : 8'h08) | k[7:0]};
      ins(1'b0, TAD_K_MOV_R, 3'd1, 18'd4);
      chk("greg", 18'(k), {15'h0, dec_out.greg});
      chk("mov store", 18'(k[0]), {17'h0, dec_out.store});
    end
    q = {8'h11};
    ins(1'b0, TAD_K_SWAP_PAIR, 3'd1, 18'd4);
    ins(1'b1, TAD_K_SWAP_PAIR, 3'd1, 18'd4);
    q = {8'h10};
    ins(1'b0, TAD_K_SWAP_ACC, 3'd1, 18'd4);
    q = {8'h50};
    ins(1'b0, TAD_K_SWAP_PTR, 3'd1, 18'd4);
    q = {8'h70, 8'h6e, 8'h34, 8'h12};
    ins(1'b0, TAD_K_MOV_DIR, 3'd4, 18'd17);
    chk("dir addr", 18'h1234, {2'h0, dec_out.addr});
    chk("dir greg", 18'h6, {15'h0, dec_out.greg});
    q = {8'h70, 8'h79, 8'hcd, 8'hab};
    ins(1'b0, TAD_K_MOV_DIR, 3'd4, 18'd17);
    chk("dir store", 18'h1, {17'h0, dec_out.store});
    q = {8'h6b, 8'h5a};
    ins(1'b0, TAD_K_MVI, 3'd2, 18'd7);
    chk("mvi data", 18'h5a, {10'h0, dec_out.data});
    ins(1'b1, TAD_K_MVI, 3'd2, 18'd8);
    q = {8'h71, 8'h42, 8'h99};
    ins(1'b1, TAD_K_MVW, 3'd3, 18'd11);
    ins(1'b0, TAD_K_MVW, 3'd3, 18'd13);
    chk("mvw data", 18'h99, {10'h0, dec_out.data});
    q = {8'h63, 8'h7e};
    vv = seed[23:16];
    ins(1'b0, TAD_K_WORK, 3'd2, 18'd10);
    chk("work addr", {2'h0, vv, 8'h7e}, {2'h0, dec_out.addr});
    q = {8'h01, 8'h7e};
    ins(1'b0, TAD_K_WORK, 3'd2, 18'd10);
    chk("work load", 18'h0, {17'h0, dec_out.store});
    for (k = 1; k < 16; k++) begin
      if (k == 8 || k == 9 || k == 10) continue;
      q = {8'h28 | {k[3], 2'h0, k[0], 1'h0, k[2:0]}};
      if (k == 11 || k == 15) q.push_back(8'h5c);
      ins(1'b0, TAD_K_IND, 3'd0, (k < 8) ? 18'd7 : 18'd13);
      chk("amode", 18'(k), {14'h0, dec_out.amode});
      chk("ind store", 18'(k[0]), {17'h0, dec_out.store});
      chk("adj", (k == 4 || k == 5) ? 18'h1 : (k == 6 || k == 7) ? 18'h7 : 18'h0, {15'h0, dec_out.ptr_adj});
      if (k == 11 || k == 15) chk("disp", 18'h5c, {10'h0, dec_out.disp});
    end
    q = {8'h31};
    ins(1'b0, TAD_K_BLOCK, 3'd1, 18'd13 * ({10'h0, seed[7:0]} + 18'd1));
    for (k = 0; k < 5; k++) begin
      q = {8'hb0 | k[7:0]};
      ins(1'b0, TAD_K_PUSH, 3'd1, 18'd13);
      chk("push pair", (k == 0) ? 18'h5 : 18'(k), {15'h0, dec_out.pair});
      q = {8'ha0 | k[7:0]};
      ins(1'b0, TAD_K_POP, 3'd1, 18'd10);
    end
    for (k = 0; k < 4; k++) begin
      if (k > 0) begin
        q = {(k[1] ? 8'hb4 : 8'ha4) | k[7:0]};
        ins(1'b0, TAD_K_WIDE_MOVE, 3'd1, 18'd4);
        chk("wide_move pair", 18'(k), {15'h0, dec_out.pair});
        chk("wide_move store", 18'(k[1]), {17'h0, dec_out.store});
      end
      q = {8'h70, 8'h0e | {k[3:0], 4'h0} | 8'(k[0]), 8'h10, 8'h20};
      ins(1'b0, TAD_K_DIR_PAIR, 3'd4, 18'd20);
      chk("pair", 18'(k), {15'h0, dec_out.pair});
      chk("pair addr", 18'h2010, {2'h0, dec_out.addr});
      chk("pair store", 18'(!k[0]), {17'h0, dec_out.store});
    end
    q = {8'h14, 8'h34, 8'h12};
    ins(1'b0, TAD_K_LXI, 3'd3, 18'd10);
    chk("lxi pair", 18'h1, {15'h0, dec_out.pair});
    chk("lxi addr", 18'h1234, {2'h0, dec_out.addr});
    q = {8'h60, seed[7:0]};
    ins(1'b0, TAD_K_ARITH_R, 3'd2, 18'd8);
    chk("arith greg", 18'(q[1][2:0]), {15'h0, dec_out.greg});
    q = {8'h70, 8'hc3};
    ins(1'b0, TAD_K_ARITH_M, 3'd2, 18'd11);
    chk("arith amode", 18'h3, {14'h0, dec_out.amode});
    q = {8'h48, 8'ha8};
    ta = seed[31:16] + 16'd3 + {8'h00, seed[15:8]};
    ins(1'b0, TAD_K_TABLE, 3'd2, 18'd17);
    chk("table addr", {2'h0, ta}, {2'h0, dec_out.addr});
    q = {8'h4c, 8'he0};
    ins(1'b0, TAD_K_MOV_SR, 3'd2, 18'd10);
    chk("conv", 18'h1, {17'h0, sreg_conv_out});
    q = {8'h4d, 8'hc6};
    ins(1'b0, TAD_K_MOV_SR, 3'd2, 18'd10);
    chk("sreg", 18'h6, {12'h0, dec_out.sreg});
    chk("no conv", 18'h0, {17'h0, sreg_conv_out});
    for (k = 0; k < 4; k++) begin
      q = {8'h48, (k[1] ? 8'hd2 : 8'hc0) | 8'(k[0])};
      ins(1'b0, TAD_K_WIDE_MOVE_SR, 3'd2, 18'd14);
      chk("sel", 18'(k[0]), {17'h0, dec_out.sel});
      chk("wide_move sr store", 18'(k[1]), {17'h0, dec_out.store});
    end
    q = {8'h48, 8'h9f, 8'h33};
    ins(1'b0, TAD_K_WIDE, 3'd3, 18'd20);
    chk("wide disp", 18'h133, {9'h0, dec_out.store, dec_out.disp});
    q = {8'h48, 8'h84, 8'h00};
    ins(1'b0, TAD_K_WIDE, 3'd3, 18'd14);
    chk("wide mode", 18'h4, {14'h0, dec_out.amode});
    chk("wide adj", 18'h2, {15'h0, dec_out.ptr_adj});
    for (k = 0; k < 32; k++) begin
      @(posedge sys_clk_in);
      irf_code_in <= k[4:0];
      @(posedge sys_clk_in);
      #1;
      chk("irf", (k < 13) ? 18'h1 << k : (k > 15 && k < 21) ? 18'h1 << (k - 3) : 18'h0, irf_sel_out);
    end
    complete_run();
  end
endmodule : test_tad_decoder
`default_nettype wire
